// File: sprc_pkg.sv
/*
 * Shared constants for the supply regulator and power-fail control block:
 * register byte offsets, field positions, reset values and timing.
 * Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
 */
package sprc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets (each register one aligned word)
  localparam logic [7:0] SPRC_OFS_MODE_STATUS = 8'h00; // supply_mode_status
  localparam logic [7:0] SPRC_OFS_SW1_ENABLE  = 8'h04; // stage1_switcher_enable
  localparam logic [7:0] SPRC_OFS_SW2_ENABLE  = 8'h08; // stage2_switcher_enable
  localparam logic [7:0] SPRC_OFS_STAGE1_LVL  = 8'h0C; // stage1_output_level
  localparam logic [7:0] SPRC_OFS_PF_CONTROL  = 8'h10; // powerfail_control
  localparam logic [7:0] SPRC_OFS_PF_EVENT    = 8'h14; // powerfail_warning_event
  localparam logic [7:0] SPRC_OFS_SUPERVISOR  = 8'h18; // supervisor status

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SPRC_BIT_HIGH_MODE = 0; // mode status: 1 = high voltage
  localparam int SPRC_BIT_ENABLE    = 0; // switcher / comparator enable
  localparam int SPRC_POS_THRESHOLD = 1; // powerfail_control threshold lsb
  localparam int SPRC_BIT_EVENT     = 0; // warning event flag
  localparam int SPRC_BIT_BELOW     = 0; // supervisor: supply below threshold
  localparam int SPRC_BIT_ACTIVE    = 1; // supervisor: comparator active
  localparam int SPRC_BIT_BLOCKED   = 2; // supervisor: flash writes blocked
  localparam int SPRC_BIT_RELEASED  = 3; // supervisor: system out of reset

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic       SPRC_RST_SW_ENABLE = 1'b0; // linear operation
  localparam logic       SPRC_RST_PF_ENABLE = 1'b0; // comparator off
  localparam logic [7:0] SPRC_RST_STAGE1_LVL = 8'h00;
  localparam logic [7:0] SPRC_RST_THRESHOLD  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // bus answers
  localparam logic [1:0] SPRC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPRC_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SPRC_CLK_MHZ     = 50;
  localparam int SPRC_POR_HOLD_NS = 1000; // least power-on hold after release
  localparam int SPRC_POR_CYCLES  =
    (SPRC_POR_HOLD_NS * SPRC_CLK_MHZ + 999) / 1000;

endpackage

// File: sprc_supply_ctrl.sv
/*
 * Supply regulator and power-fail control: AXI4-Lite register slave,
 * regulator stage enables, power-on/brownout reset hold and the
 * power-fail comparator with its warning event and flash write block.
 * Assumes supply_code is an already digitised supply reading and all
 * inputs are synchronous to aclk.
 */
// Register access over AXI4-Lite and the placing of the registers were decided locally.
//
// How it works
// - supply mode readable as normal or high voltage in a status register
// - normal mode uses stage two only; stage one kept disabled
// - high mode runs both stages, stage one feeding stage two
// - after reset switchers off; stage two and, in high mode, stage one run linear
// - two independent switcher enables, one per stage
// - an enabled switcher turns off that stage's linear regulator
// - stage one output level held; sets io high level in high mode
// - brownout holds system reset; power-on reset signalled on connection
// - comparator active only once software enables it and sets threshold
// - supply falling below threshold raises the warning event
// - event also raised if already below at enable or threshold raise
// - enabled and below threshold blocks every flash write
// - comparator inactive in system off or without fast clock
module sprc_supply_ctrl
  import sprc_pkg::*;
#(
  parameter int LEVEL_W = 3,
  parameter int THR_W   = 4
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               high_voltage_mode,
  input  wire logic               brownout_low,
  input  wire logic               system_off,
  input  wire logic               fast_clk_running,
  input  wire logic [THR_W-1:0]   supply_code,
  output logic                    stage1_ldo_on,
  output logic                    stage1_switcher_on,
  output logic                    stage2_ldo_on,
  output logic                    stage2_switcher_on,
  output logic [LEVEL_W-1:0]      stage1_output_level,
  output logic                    io_level_from_stage1,
  output logic                    powerfail_warning_event,
  output logic                    flash_write_block,
  output logic                    system_reset_n,
  output logic                    power_on_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks: fields must fit the low byte of a word
  if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_bad_level
    $error("LEVEL_W must lie in 1..8");
  end
  if (THR_W < 1 || THR_W > 7) begin : g_bad_thr
    $error("THR_W must lie in 1..7");
  end

  localparam int POR_W = $clog2(SPRC_POR_CYCLES + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(SPRC_POR_CYCLES);

  typedef struct packed {
    logic               aw_got;
    logic [7:0]         aw_addr;
    logic               w_got;
    logic [7:0]         w_byte;
    logic               w_lane;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic               sw1_en;
    logic               sw2_en;
    logic [LEVEL_W-1:0] level;
    logic               pf_en;
    logic [THR_W-1:0]   pf_thr;
    logic               pf_evt;
    logic               below_prev;
    logic [POR_W-1:0]   por_cnt;
    logic               por_done;
    logic               por_pulse;
    logic               st1_ldo;
    logic               st1_sw;
    logic               st2_ldo;
    logic               st2_sw;
    logic               blk;
    logic               rst_n;
  } sprc_state_type;

  sprc_state_type st_ff;
  sprc_state_type nxt_st;

  // address is mapped when it names one of the seven words
  function automatic logic sprc_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= SPRC_OFS_SUPERVISOR;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator conditions, shared by the process and the checks
  logic       cmp_active;
  logic       below;
  logic       do_write;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic       wr_lane;
  logic       evt_clear;

  assign cmp_active = st_ff.pf_en && !system_off && fast_clk_running;
  assign below      = supply_code < st_ff.pf_thr;

  // write fires once address and data are both in hand
  assign do_write = (st_ff.aw_got || (s_axi_awvalid && s_axi_awready)) &&
                    (st_ff.w_got || (s_axi_wvalid && s_axi_wready));
  assign wr_addr  = st_ff.aw_got ? st_ff.aw_addr : s_axi_awaddr;
  assign wr_byte  = st_ff.w_got ? st_ff.w_byte : s_axi_wdata[7:0];
  assign wr_lane  = st_ff.w_got ? st_ff.w_lane : s_axi_wstrb[0];
  assign evt_clear = do_write && wr_lane && wr_addr == SPRC_OFS_PF_EVENT &&
                     !wr_byte[SPRC_BIT_EVENT];

  // handshake readies are combinational; one write, one read at a time
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.por_pulse = 1'b0;

    // bus write side: hold each half until the other arrives
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_byte = s_axi_wdata[7:0];
      nxt_st.w_lane = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = sprc_mapped(wr_addr) ? SPRC_RESP_OKAY
                                           : SPRC_RESP_SLVERR;
      // every field sits in byte lane 0; status words ignore writes
      if (wr_lane) begin
        case (wr_addr)
          SPRC_OFS_SW1_ENABLE: nxt_st.sw1_en = wr_byte[SPRC_BIT_ENABLE];
          SPRC_OFS_SW2_ENABLE: nxt_st.sw2_en = wr_byte[SPRC_BIT_ENABLE];
          SPRC_OFS_STAGE1_LVL: nxt_st.level = wr_byte[LEVEL_W-1:0];
          SPRC_OFS_PF_CONTROL: begin
            nxt_st.pf_en  = wr_byte[SPRC_BIT_ENABLE];
            nxt_st.pf_thr = wr_byte[SPRC_POS_THRESHOLD +: THR_W];
          end
          default: ;
        endcase
      end
    end

    // bus read side: data registered one cycle after the address
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = 32'h0000_0000;
      nxt_st.rresp  = sprc_mapped(s_axi_araddr) ? SPRC_RESP_OKAY
                                                : SPRC_RESP_SLVERR;
      case (s_axi_araddr)
        SPRC_OFS_MODE_STATUS:
          nxt_st.rdata[SPRC_BIT_HIGH_MODE] = high_voltage_mode;
        SPRC_OFS_SW1_ENABLE:
          nxt_st.rdata[SPRC_BIT_ENABLE] = st_ff.sw1_en;
        SPRC_OFS_SW2_ENABLE:
          nxt_st.rdata[SPRC_BIT_ENABLE] = st_ff.sw2_en;
        SPRC_OFS_STAGE1_LVL:
          nxt_st.rdata[LEVEL_W-1:0] = st_ff.level;
        SPRC_OFS_PF_CONTROL: begin
          nxt_st.rdata[SPRC_BIT_ENABLE] = st_ff.pf_en;
          nxt_st.rdata[SPRC_POS_THRESHOLD +: THR_W] = st_ff.pf_thr;
        end
        SPRC_OFS_PF_EVENT:
          nxt_st.rdata[SPRC_BIT_EVENT] = st_ff.pf_evt;
        SPRC_OFS_SUPERVISOR: begin
          nxt_st.rdata[SPRC_BIT_BELOW]    = cmp_active && below;
          nxt_st.rdata[SPRC_BIT_ACTIVE]   = cmp_active;
          nxt_st.rdata[SPRC_BIT_BLOCKED]  = st_ff.blk;
          nxt_st.rdata[SPRC_BIT_RELEASED] = st_ff.rst_n;
        end
        default: ;
      endcase
    end

    // stage one off in normal mode on in high mode
    // a switcher displaces its own linear regulator
    nxt_st.st1_ldo = high_voltage_mode && !st_ff.sw1_en;
    nxt_st.st1_sw  = high_voltage_mode && st_ff.sw1_en;
    nxt_st.st2_ldo = !st_ff.sw2_en;
    nxt_st.st2_sw  = st_ff.sw2_en;

    // one set per entry into the below state
    // rising edge of active-and-below covers enable and threshold raise
    nxt_st.below_prev = cmp_active && below;
    if (evt_clear) begin
      nxt_st.pf_evt = 1'b0;
    end
    if (cmp_active && below && !st_ff.below_prev) begin
      nxt_st.pf_evt = 1'b1; // set wins over a clear in the same cycle
    end

    nxt_st.blk = cmp_active && below;

    // power-on hold after release, brownout holds reset at any time
    if (!st_ff.por_done) begin
      if (st_ff.por_cnt == POR_LAST) begin
        nxt_st.por_done  = 1'b1;
        nxt_st.por_pulse = 1'b1;
      end else begin
        nxt_st.por_cnt = st_ff.por_cnt + POR_W'(1);
      end
    end
    nxt_st.rst_n = st_ff.por_done && !brownout_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.sw1_en  <= SPRC_RST_SW_ENABLE;
      st_ff.sw2_en  <= SPRC_RST_SW_ENABLE;
      st_ff.st2_ldo <= 1'b1;
      st_ff.level   <= SPRC_RST_STAGE1_LVL[LEVEL_W-1:0];
      st_ff.pf_en   <= SPRC_RST_PF_ENABLE;
      st_ff.pf_thr  <= SPRC_RST_THRESHOLD[THR_W-1:0];
      st_ff.bresp   <= SPRC_RESP_OKAY;
      st_ff.rresp   <= SPRC_RESP_OKAY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the state register
  assign s_axi_bvalid            = st_ff.bvalid;
  assign s_axi_bresp             = st_ff.bresp;
  assign s_axi_rvalid            = st_ff.rvalid;
  assign s_axi_rresp             = st_ff.rresp;
  assign s_axi_rdata             = st_ff.rdata;
  assign stage1_ldo_on           = st_ff.st1_ldo;
  assign stage1_switcher_on      = st_ff.st1_sw;
  assign stage2_ldo_on           = st_ff.st2_ldo;
  assign stage2_switcher_on      = st_ff.st2_sw;
  assign stage1_output_level     = st_ff.level;
  // io high level follows stage one only while it feeds the supply pin
  assign io_level_from_stage1    = st_ff.st1_ldo || st_ff.st1_sw;
  assign powerfail_warning_event = st_ff.pf_evt;
  assign flash_write_block       = st_ff.blk;
  assign system_reset_n          = st_ff.rst_n;
  assign power_on_pulse          = st_ff.por_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  stage1_off_a: assert property (
    !high_voltage_mode |=> !stage1_ldo_on && !stage1_switcher_on)
    else $error("stage one running in normal mode");

  stage1_on_a: assert property (
    high_voltage_mode |=> stage1_ldo_on != stage1_switcher_on)
    else $error("stage one not running in high mode");

  reset_linear_a: assert property (
    $past(!aresetn) |-> !st_ff.sw1_en && !st_ff.sw2_en ##1 stage2_ldo_on)
    else $error("switcher enabled after reset");

  sw_excl_a: assert property (
    stage2_switcher_on |-> !stage2_ldo_on)
    else $error("switcher and linear both on");

  brownout_hold_a: assert property (
    brownout_low |=> !system_reset_n)
    else $error("brownout did not hold reset");

  warn_raise_a: assert property (
    cmp_active && below && !st_ff.below_prev |=> powerfail_warning_event)
    else $error("warning not raised on crossing");

  warn_cause_a: assert property (
    $rose(powerfail_warning_event) |-> $past(cmp_active && below))
    else $error("warning raised without low supply");

  flash_block_a: assert property (
    cmp_active && below |=> flash_write_block)
    else $error("flash writes not blocked");

  pf_idle_a: assert property (
    system_off || !fast_clk_running |=> !flash_write_block)
    else $error("comparator active while gated");

  warn_sticky_a: assert property (
    powerfail_warning_event && !evt_clear |=> powerfail_warning_event)
    else $error("warning dropped without clear");

  pf_enable_a: assert property (
    !st_ff.pf_en |=> !flash_write_block && !$rose(powerfail_warning_event))
    else $error("comparator acting while disabled");

  bus_resp_a: assert property (
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

endmodule

// File: sprc_tb.sv
/*
 * Self-checking bench for the supply regulator and power-fail control block:
 * AXI4-Lite read/write tasks, regulator, reset and comparator sequences.
 * Assumes sprc_pkg is compiled first and the design uses its default widths.
 */
module tb
  import sprc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CEIL = 5000; // a few hundred bus cycles expected

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        high_voltage_mode;
  logic        brownout_low;
  logic        system_off;
  logic        fast_clk_running;
  logic [3:0]  supply_code;
  logic        stage1_ldo_on;
  logic        stage1_switcher_on;
  logic        stage2_ldo_on;
  logic        stage2_switcher_on;
  logic [2:0]  stage1_output_level;
  logic        io_level_from_stage1;
  logic        powerfail_warning_event;
  logic        flash_write_block;
  logic        system_reset_n;
  logic        power_on_pulse;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cycles = 0;

  sprc_supply_ctrl #(.LEVEL_W(3), .THR_W(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .high_voltage_mode(high_voltage_mode), .brownout_low(brownout_low),
    .system_off(system_off), .fast_clk_running(fast_clk_running),
    .supply_code(supply_code), .stage1_ldo_on(stage1_ldo_on),
    .stage1_switcher_on(stage1_switcher_on), .stage2_ldo_on(stage2_ldo_on),
    .stage2_switcher_on(stage2_switcher_on),
    .stage1_output_level(stage1_output_level),
    .io_level_from_stage1(io_level_from_stage1),
    .powerfail_warning_event(powerfail_warning_event),
    .flash_write_block(flash_write_block),
    .system_reset_n(system_reset_n), .power_on_pulse(power_on_pulse));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      n_fail++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; leaves one idle edge behind
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, 4'h1, SPRC_RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, SPRC_RESP_OKAY, d);
    chk(d, e);
  endtask

  // event and flash block, compared once the inputs have settled
  task automatic ev(input logic e, input logic b);
    repeat (3) @(posedge aclk);
    chk(32'({powerfail_warning_event, flash_write_block}), 32'({e, b}));
  endtask

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] d;
    logic        hv;
    logic        s1;
    logic        s2;
    int          cnt;
    logic        seen;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, high_voltage_mode} = 3'h0;
    {brownout_low, system_off, fast_clk_running} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    supply_code = 4'hA;
    repeat (20) @(posedge aclk);
    chk(32'({stage1_ldo_on, stage1_switcher_on, stage2_ldo_on,
             stage2_switcher_on, powerfail_warning_event, flash_write_block,
             system_reset_n, power_on_pulse}), 32'h20);
    aresetn <= 1'b1;
    cnt = 0;
    seen = 1'b0;
    // power-on hold must last the full count, ending with one pulse
    while (system_reset_n !== 1'b1) begin
      @(posedge aclk);
      cnt++;
      if (power_on_pulse === 1'b1) seen = 1'b1;
    end
    chk(32'(cnt >= SPRC_POR_CYCLES && seen), 32'h1);
    for (int k = 1; k < 6; k++) rchk(8'(4 * k), 32'h0);
    brownout_low <= 1'b1;
    ev(1'b0, 1'b0);
    chk(32'(system_reset_n), 32'h0);
    brownout_low <= 1'b0;
    // release lands one edge after brownout clears, so let it settle
    repeat (2) @(posedge aclk);
    chk(32'(system_reset_n), 32'h1);
    rchk(SPRC_OFS_SUPERVISOR, 32'h8);
    // every mode and switcher combination
    // filters taken as fitted
    for (int i = 0; i < 8; i++) begin
      {hv, s1, s2} = 3'(i);
      high_voltage_mode <= hv;
      w(SPRC_OFS_SW1_ENABLE, 32'(s1));
      w(SPRC_OFS_SW2_ENABLE, 32'(s2));
      chk(32'({stage1_ldo_on, stage1_switcher_on, stage2_ldo_on,
               stage2_switcher_on}),
          32'({hv & !s1, hv & s1, !s2, s2}));
      chk(32'(io_level_from_stage1), 32'(hv));
      rchk(SPRC_OFS_MODE_STATUS, 32'(hv));
      rchk(SPRC_OFS_SW1_ENABLE, 32'(s1));
    end
    high_voltage_mode <= 1'b0;
    wr(SPRC_OFS_SW2_ENABLE, 32'h0, 4'h0, SPRC_RESP_OKAY);
    rchk(SPRC_OFS_SW2_ENABLE, 32'h1);
    w(SPRC_OFS_MODE_STATUS, 32'h1);
    rchk(SPRC_OFS_MODE_STATUS, 32'h0);
    w(SPRC_OFS_STAGE1_LVL, 32'hFF);
    chk(32'(stage1_output_level), 32'h7);
    rchk(SPRC_OFS_STAGE1_LVL, 32'h7);
    wr(8'h1C, 32'h1, 4'h1, SPRC_RESP_SLVERR);
    rd(8'h1C, SPRC_RESP_SLVERR, d);
    // comparator: threshold 5, supply 10 then 3
    w(SPRC_OFS_PF_CONTROL, 32'h0B);
    ev(1'b0, 1'b0);
    rchk(SPRC_OFS_SUPERVISOR, 32'hA);
    supply_code <= 4'h3;
    ev(1'b1, 1'b1);
    rchk(SPRC_OFS_PF_EVENT, 32'h1);
    w(SPRC_OFS_PF_EVENT, 32'h1);
    ev(1'b1, 1'b1);
    w(SPRC_OFS_PF_EVENT, 32'h0);
    ev(1'b0, 1'b1);
    supply_code <= 4'hA;
    ev(1'b0, 1'b0);
    supply_code <= 4'h8;
    ev(1'b0, 1'b0);
    w(SPRC_OFS_PF_CONTROL, 32'h19);
    ev(1'b1, 1'b1);
    w(SPRC_OFS_PF_CONTROL, 32'h18);
    w(SPRC_OFS_PF_EVENT, 32'h0);
    ev(1'b0, 1'b0);
    w(SPRC_OFS_PF_CONTROL, 32'h19);
    ev(1'b1, 1'b1);
    w(SPRC_OFS_PF_EVENT, 32'h0);
    system_off <= 1'b1;
    ev(1'b0, 1'b0);
    rchk(SPRC_OFS_SUPERVISOR, 32'h8);
    system_off <= 1'b0;
    fast_clk_running <= 1'b0;
    ev(1'b0, 1'b0);
    fast_clk_running <= 1'b1;
    ev(1'b1, 1'b1);
    // mid-run reset with both switchers still enabled
    chk(32'(stage2_switcher_on), 32'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({stage1_switcher_on, stage2_ldo_on, stage2_switcher_on}),
        32'h2);
    rchk(SPRC_OFS_SW1_ENABLE, 32'h0);
    rchk(SPRC_OFS_SW2_ENABLE, 32'h0);
    wrap_up();
  end
endmodule
